// >>> ccx_core.sv
`timescale 1ns/100ps
module ccx_core (
	input wire logic clock,
	input wire logic srst,
	input wire ccx_pkg::ccx_instr_t instr,
	input wire logic prescaler_to_watchdog,
	input wire logic watchdog_tick,
	input wire logic timeout_event,
	input wire logic sleep_event,
	input wire logic [ccx_pkg::CCX_ADDR_W-1:0] peek_addr,
	output logic [ccx_pkg::CCX_DATA_W-1:0] peek_data,
	output ccx_pkg::ccx_state_t state_out
);
	import ccx_pkg::*;

	// All state in one struct, file registers included
	typedef struct packed {
		ccx_state_t core;
		logic [CCX_FILE_DEPTH-1:0][CCX_DATA_W-1:0] file;
	} ccx_all_t;

	ccx_all_t st; // Registered state
	ccx_all_t next_st; // Next state
	logic [CCX_DATA_W-1:0] operand; // Addressed register value
	logic [CCX_DATA_W-1:0] inv; // Complemented operand

	// Operand read straight from the file, so each op ends in its own cycle
	assign operand = st.file[instr.addr];
	assign inv = ~operand;

	// Next-state logic; every op completes in this one cycle
	always_comb begin
		next_st = st;
		// Watchdog counts on ticks, prescaler too when assigned to it; a clear wins over a tick
		if (watchdog_tick) begin
			next_st.core.watchdog_counter = st.core.watchdog_counter + 8'h01;
			if (prescaler_to_watchdog) begin
				next_st.core.prescaler = st.core.prescaler + 8'h01;
			end
		end
		// Outside events that drop the status bits
		if (timeout_event) begin
			next_st.core.timeout_status_n = 1'b0;
		end
		if (sleep_event) begin
			next_st.core.powerdown_status_n = 1'b0;
		end
		// Decode the one instruction of this cycle; only the watchdog clear overrides ticks and events
		case (instr.op)
			clear_accumulator_op: begin
				next_st.core.acc = CCX_ZERO_BYTE;
				next_st.core.zero_flag = 1'b1;
			end
			clear_file_register_op: begin
				next_st.file[instr.addr] = CCX_ZERO_BYTE;
				next_st.core.zero_flag = 1'b1;
			end
			clear_watchdog_op: begin
				next_st.core.watchdog_counter = CCX_ZERO_BYTE;
				if (prescaler_to_watchdog) begin
					next_st.core.prescaler = CCX_ZERO_BYTE;
				end
				// raise both status bits; the instruction wins over events
				next_st.core.timeout_status_n = 1'b1;
				next_st.core.powerdown_status_n = 1'b1;
			end
			complement_register_op: begin
				if (instr.dest == CCX_DEST_REG) begin
					next_st.file[instr.addr] = inv;
				end else begin
					next_st.core.acc = inv;
				end
				next_st.core.zero_flag = (inv == CCX_ZERO_BYTE);
			end
			default: begin
				// No operation for this block
			end
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge clock) begin
		if (srst) begin
			// Every field to its reset value, file included
			st.core.acc <= CCX_ACC_RST;
			st.core.zero_flag <= CCX_ZERO_FLAG_RST;
			st.core.timeout_status_n <= CCX_STATUS_N_RST;
			st.core.powerdown_status_n <= CCX_STATUS_N_RST;
			st.core.watchdog_counter <= CCX_ZERO_BYTE;
			st.core.prescaler <= CCX_ZERO_BYTE;
			st.file <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Core state leaves straight from the flops
	assign state_out = st.core;
	// Read port for the bench; a mux of flops, so no extra latency
	assign peek_data = st.file[peek_addr];

	// Assertions
	// accumulator clear check
	property p_clear_acc;
		@(posedge clock) disable iff (srst)
		instr.op == clear_accumulator_op |=> state_out.acc == 8'h00 && state_out.zero_flag;
	endproperty
	a_clear_acc: assert property (p_clear_acc) else $error("acc clear failed");

	property p_clear_acc_file;
		@(posedge clock) disable iff (srst)
		instr.op == clear_accumulator_op |=> $stable(st.file);
	endproperty
	a_clear_acc_file: assert property (p_clear_acc_file) else $error("file changed by acc clear");

	property p_clear_reg;
		logic [5:0] a;
		@(posedge clock) disable iff (srst)
		(instr.op == clear_file_register_op, a = instr.addr) |=> st.file[a] == 8'h00 && state_out.zero_flag;
	endproperty
	a_clear_reg: assert property (p_clear_reg) else $error("register clear failed");

	property p_clear_reg_acc;
		@(posedge clock) disable iff (srst)
		instr.op == clear_file_register_op |=> $stable(state_out.acc);
	endproperty
	a_clear_reg_acc: assert property (p_clear_reg_acc) else $error("acc changed by register clear");

	property p_watchdog_clear;
		@(posedge clock) disable iff (srst)
		instr.op == clear_watchdog_op |=> state_out.watchdog_counter == 8'h00;
	endproperty
	a_watchdog_clear: assert property (p_watchdog_clear) else $error("watchdog not cleared");

	property p_watchdog_tick;
		@(posedge clock) disable iff (srst)
		instr.op != clear_watchdog_op && watchdog_tick
			|=> state_out.watchdog_counter == $past(state_out.watchdog_counter) + 8'h01;
	endproperty
	a_watchdog_tick: assert property (p_watchdog_tick) else $error("watchdog count did not advance");

	property p_prescaler_clear;
		@(posedge clock) disable iff (srst)
		instr.op == clear_watchdog_op |=>
			(($past(prescaler_to_watchdog) && state_out.prescaler == 8'h00)
			|| (!$past(prescaler_to_watchdog) && $stable(state_out.prescaler)));
	endproperty
	a_prescaler_clear: assert property (p_prescaler_clear) else $error("prescaler handling wrong");

	property p_status_set;
		@(posedge clock) disable iff (srst)
		instr.op == clear_watchdog_op |=> state_out.timeout_status_n && state_out.powerdown_status_n;
	endproperty
	a_status_set: assert property (p_status_set) else $error("status bits not set");

	property p_status_event;
		@(posedge clock) disable iff (srst)
		instr.op != clear_watchdog_op && (timeout_event || sleep_event)
			|=> (!$past(timeout_event) || !state_out.timeout_status_n) && (!$past(sleep_event) || !state_out.powerdown_status_n);
	endproperty
	a_status_event: assert property (p_status_event) else $error("status event not recorded");

	property p_status_zero_hold;
		@(posedge clock) disable iff (srst)
		instr.op == clear_watchdog_op |=> $stable(state_out.zero_flag) && $stable(state_out.acc);
	endproperty
	a_status_zero_hold: assert property (p_status_zero_hold) else $error("watchdog clear touched acc");

	property p_comp_acc;
		logic [7:0] v;
		logic [5:0] a;
		@(posedge clock) disable iff (srst)
		(instr.op == complement_register_op && instr.dest == CCX_DEST_ACC, v = ~operand, a = instr.addr)
			|=> state_out.acc == v && st.file[a] == ~v;
	endproperty
	a_comp_acc: assert property (p_comp_acc) else $error("complement to acc wrong");

	property p_comp_reg;
		logic [7:0] v;
		logic [5:0] a;
		@(posedge clock) disable iff (srst)
		(instr.op == complement_register_op && instr.dest == CCX_DEST_REG, v = ~operand, a = instr.addr)
			|=> st.file[a] == v && $stable(state_out.acc);
	endproperty
	a_comp_reg: assert property (p_comp_reg) else $error("complement to register wrong");

	property p_comp_zero;
		@(posedge clock) disable iff (srst)
		instr.op == complement_register_op |=> state_out.zero_flag == ($past(operand) == 8'hff);
	endproperty
	a_comp_zero: assert property (p_comp_zero) else $error("complement zero flag wrong");

	property p_nop_hold;
		@(posedge clock) disable iff (srst)
		instr.op == ccx_nop_op && !watchdog_tick && !timeout_event && !sleep_event
			|=> $stable(state_out) && $stable(st.file);
	endproperty
	a_nop_hold: assert property (p_nop_hold) else $error("idle cycle changed state");

	// Main scenarios reached
	c_clear_acc: cover property (@(posedge clock) disable iff (srst) instr.op == clear_accumulator_op);
	c_watchdog_own: cover property (@(posedge clock) disable iff (srst)
		instr.op == clear_watchdog_op && prescaler_to_watchdog);
	c_watchdog_timer: cover property (@(posedge clock) disable iff (srst)
		instr.op == clear_watchdog_op && !prescaler_to_watchdog);
	c_comp_zero: cover property (@(posedge clock) disable iff (srst)
		instr.op == complement_register_op && operand == 8'hff);
	c_comp_reg: cover property (@(posedge clock) disable iff (srst)
		instr.op == complement_register_op && instr.dest == CCX_DEST_REG);
endmodule

// >>> ccx_pkg.sv
// Notes on behaviour
// - Clear accumulator: zero it, set zero flag
// - Clear file register 0..63: zero it, set zero
// - Clear watchdog resets watchdog counter to zero
// - Prescaler cleared only when assigned to watchdog
// - Clear watchdog sets timeout and powerdown status
// - Complement register; destination bit picks accumulator/register
package ccx_pkg;
	// Operation select presented by the fetch stage
	typedef enum logic [2:0] {
		ccx_nop_op,
		clear_accumulator_op,
		clear_file_register_op,
		clear_watchdog_op,
		complement_register_op
	} ccx_op_t;

	// Widths
	localparam int CCX_DATA_W = 8;
	localparam int CCX_ADDR_W = 6;
	localparam int CCX_WATCHDOG_W = 8;
	localparam int CCX_PRE_W = 8;
	localparam int CCX_FILE_DEPTH = 64;

	// Reset values
	localparam logic [7:0] CCX_ZERO_BYTE = 8'h00;
	localparam logic [7:0] CCX_ACC_RST = 8'h00;
	localparam logic CCX_ZERO_FLAG_RST = 1'b0;
	localparam logic CCX_STATUS_N_RST = 1'b1;

	// Destination bit encoding
	localparam logic CCX_DEST_ACC = 1'b0;
	localparam logic CCX_DEST_REG = 1'b1;

	// One decoded instruction
	typedef struct packed {
		ccx_op_t op;
		logic [CCX_ADDR_W-1:0] addr;
		logic dest;
	} ccx_instr_t;

	// Core state visible outside
	typedef struct packed {
		logic [CCX_DATA_W-1:0] acc;
		logic zero_flag;
		logic timeout_status_n;
		logic powerdown_status_n;
		logic [CCX_WATCHDOG_W-1:0] watchdog_counter;
		logic [CCX_PRE_W-1:0] prescaler;
	} ccx_state_t;
endpackage

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
	import ccx_pkg::*;
	// One instruction and what it should leave in acc, zero flag and the file
	typedef struct packed {
		ccx_op_t op;
		logic [5:0] addr;
		logic dest;
		logic [7:0] acc;
		logic zf;
		logic [7:0] file;
	} ccx_row_t;
	logic clock = 1'b0;
	logic srst = 1'b1;
	ccx_instr_t instr = '0;
	logic p2w = 1'b0;
	logic tick = 1'b0;
	logic tev = 1'b0;
	logic sev = 1'b0;
	logic [5:0] peek_addr = 6'h00;
	logic [7:0] peek_data;
	ccx_state_t st;
	int num_errors = 0;
	int cmp_count = 0;
	// Rows chain on each other, so order matters; top address 63 is the edge case
	ccx_row_t rows [7] = '{
		'{complement_register_op, 6'h3f, 1'b1, 8'h00, 1'b0, 8'hff},
		'{complement_register_op, 6'h3f, 1'b0, 8'h00, 1'b1, 8'hff},
		'{complement_register_op, 6'h00, 1'b0, 8'hff, 1'b0, 8'h00},
		'{clear_file_register_op, 6'h3f, 1'b0, 8'hff, 1'b1, 8'h00},
		'{complement_register_op, 6'h3f, 1'b1, 8'hff, 1'b0, 8'hff},
		'{clear_accumulator_op, 6'h3f, 1'b0, 8'h00, 1'b1, 8'hff},
		'{ccx_nop_op, 6'h3f, 1'b0, 8'h00, 1'b1, 8'hff}};

	ccx_core dut (
		.clock(clock),
		.srst(srst),
		.instr(instr),
		.prescaler_to_watchdog(p2w),
		.watchdog_tick(tick),
		.timeout_event(tev),
		.sleep_event(sev),
		.peek_addr(peek_addr),
		.peek_data(peek_data),
		.state_out(st)
	);

	// Free-running 40 MHz clock
	initial begin
		forever #12.5 clock = ~clock;
	end
	// Hang guard, a few times the expected run length
	initial begin
		#5000;
		num_errors++;
		conclude();
	end

	// Compare one value; zero flags are widened so unknowns still mismatch
	task check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One clock, then let the edge's updates land before sampling
	task step;
		@(posedge clock);
		#1;
	endtask

	// Verdict and end of run
	task conclude;
		if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (10) step();
		srst = 1'b0;
		check(st.acc, 8'h00);
		check({st.timeout_status_n, st.powerdown_status_n}, 8'h03);
		// Back-to-back table rows, one instruction per cycle
		for (int i = 0; i < 7; i++) begin
			instr = '{rows[i].op, rows[i].addr, rows[i].dest};
			peek_addr = rows[i].addr;
			step();
			check(st.acc, rows[i].acc);
			check(st.zero_flag, rows[i].zf);
			check(peek_data, rows[i].file);
		end
		// Count up with prescaler on the watchdog, then drop both status bits
		p2w = 1'b1;
		tick = 1'b1;
		repeat (3) step();
		tick = 1'b0;
		tev = 1'b1;
		sev = 1'b1;
		step();
		tev = 1'b0;
		sev = 1'b0;
		check(st.watchdog_counter, 8'h03);
		check({st.timeout_status_n, st.powerdown_status_n}, 8'h00);
		// Clear while prescaler belongs to the timer, racing a tick
		instr.op = clear_watchdog_op;
		p2w = 1'b0;
		tick = 1'b1;
		step();
		tick = 1'b0;
		check(st.watchdog_counter, 8'h00);
		check(st.prescaler, 8'h03);
		check({st.timeout_status_n, st.powerdown_status_n}, 8'h03);
		// Clear again with prescaler handed back to the watchdog
		p2w = 1'b1;
		step();
		check(st.prescaler, 8'h00);
		// Mid-run reset wipes the file and zero flag
		instr.op = ccx_nop_op;
		srst = 1'b1;
		step();
		srst = 1'b0;
		check(peek_data, 8'h00);
		check(st.zero_flag, 8'h00);
		conclude();
	end
endmodule
